// File: rdsrb_consts.vh
`ifndef RDSRB_CONSTS_VH
`define RDSRB_CONSTS_VH

// ----------------------------------------------------------------------------
// Control bank addresses
// ----------------------------------------------------------------------------
`define RDSRB_ADDR_SEL01      3'h0
`define RDSRB_ADDR_SEL23      3'h1
`define RDSRB_ADDR_SEL45      3'h2
`define RDSRB_ADDR_SEL67      3'h3
`define RDSRB_ADDR_DIAGEN_LO  3'h4
`define RDSRB_ADDR_DIAGEN_HI  3'h5
`define RDSRB_ADDR_CMD        3'h6
`define RDSRB_ADDR_UNUSED     3'h7
`define RDSRB_CTRL_STORED     6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RDSRB_CTRL_RESET      4'h0
`define RDSRB_TER_RESET       1'b1
`define RDSRB_SYNC_RESET      6'h20

// ----------------------------------------------------------------------------
// Command register bits
// ----------------------------------------------------------------------------
`define RDSRB_CMD_WAKE        3
`define RDSRB_CMD_STANDBY     2
`define RDSRB_CMD_SOFTRST     1
`define RDSRB_CMD_CPL         0

// ----------------------------------------------------------------------------
// Frame fields
// ----------------------------------------------------------------------------
`define RDSRB_FRM_WRITE       7
`define RDSRB_FRM_ADDR_HI     6
`define RDSRB_FRM_ADDR_LO     4
`define RDSRB_FRM_DATA_HI     3
`define RDSRB_FRM_DATA_LO     0
`define RDSRB_FRM_RD_STD      1
`define RDSRB_FRM_BANK        0
`define RDSRB_FRAME_BITS      8

// ----------------------------------------------------------------------------
// Standard diagnosis word bits
// ----------------------------------------------------------------------------
`define RDSRB_STD_OPENLOAD    6
`define RDSRB_STD_AWAKE       5
`define RDSRB_STD_LIMPHOME    4

// ----------------------------------------------------------------------------
// Source selector codes
// ----------------------------------------------------------------------------
`define RDSRB_SRC_OFF         2'h0
`define RDSRB_SRC_IN1         2'h1
`define RDSRB_SRC_IN23        2'h2
`define RDSRB_SRC_ON          2'h3

// ----------------------------------------------------------------------------
// Pending read kinds
// ----------------------------------------------------------------------------
`define RDSRB_REQ_STD         2'h0
`define RDSRB_REQ_CTRL        2'h1
`define RDSRB_REQ_DIAG        2'h2

`endif

// File: rdsrb_sync.v
`timescale 1ns/1ps

module rdsrb_sync #(
    parameter              WIDTH     = 1,
    parameter [WIDTH-1:0]  RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire              clock,
    input  wire              rstn,
    // Asynchronous in, synchronous out
    input  wire [WIDTH-1:0]  din,
    output wire [WIDTH-1:0]  dout
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gBit
            reg stage1_q;
            reg stage2_q;
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stage1_q <= RESET_VAL[g];
                    stage2_q <= RESET_VAL[g];
                end else begin
                    stage1_q <= din[g];
                    stage2_q <= stage1_q;
                end
            end
            assign dout[g] = stage2_q;
        end
    endgenerate

endmodule // rdsrb_sync

// File: rdsrb_core.v
`timescale 1ns/1ps
`include "rdsrb_consts.vh"

module rdsrb_core (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // Serial pins
    input  wire        csn,
    input  wire        sclk,
    input  wire        si,
    output wire        soOut,
    output wire        soOe,
    // Parallel input pins
    input  wire        parIn1,
    input  wire        parIn2,
    input  wire        parIn3,
    // Power stage status
    input  wire [7:0]  faultIn,
    input  wire [7:0]  openLoadIn,
    input  wire        awakeIn,
    input  wire        limpHomeIn,
    // Control outputs
    output wire [7:0]  chanOn,
    output wire [7:0]  diagEnable,
    output wire        wakeCmd,
    output wire        standbyCmd,
    output wire        softResetCmd,
    output wire        cplBit,
    output wire        terFlag
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    wire [5:0]  syncOut;
    wire        csnS;
    wire        sclkS;
    wire        siS;
    wire        in1S;
    wire        in2S;
    wire        in3S;

    rdsrb_sync #(
        .WIDTH     (6),
        .RESET_VAL (`RDSRB_SYNC_RESET)
    ) uSync (
        .clock (clock),
        .rstn  (rstn),
        .din   ({csn, sclk, si, parIn1, parIn2, parIn3}),
        .dout  (syncOut)
    );

    assign csnS  = syncOut[5];
    assign sclkS = syncOut[4];
    assign siS   = syncOut[3];
    assign in1S  = syncOut[2];
    assign in2S  = syncOut[1];
    assign in3S  = syncOut[0];

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    reg         csnPrev_q;
    reg         sclkPrev_q;
    wire        csnFall;
    wire        csnRise;
    wire        sclkRise;
    wire        sclkFall;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            csnPrev_q  <= 1'b1;
            sclkPrev_q <= 1'b0;
        end else begin
            csnPrev_q  <= csnS;
            sclkPrev_q <= sclkS;
        end
    end

    assign csnFall  = csnPrev_q & ~csnS;
    assign csnRise  = ~csnPrev_q & csnS;
    assign sclkRise = ~csnS & ~csnPrev_q & sclkS & ~sclkPrev_q;
    assign sclkFall = ~csnS & ~csnPrev_q & ~sclkS & sclkPrev_q;

    // ------------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------------
    reg  [7:0]  shift_q;
    reg  [2:0]  bitCnt_q;
    reg         anyBit_q;
    wire        frameValid;
    wire        frameWrite;
    wire [2:0]  frameAddr;
    wire [3:0]  frameData;
    wire        cmdWrite;
    wire        defaultsCmd;

    assign frameValid  = csnRise & anyBit_q & (bitCnt_q == 3'h0);
    assign frameWrite  = frameValid & shift_q[`RDSRB_FRM_WRITE];
    assign frameAddr   = shift_q[`RDSRB_FRM_ADDR_HI:`RDSRB_FRM_ADDR_LO];
    assign frameData   = shift_q[`RDSRB_FRM_DATA_HI:`RDSRB_FRM_DATA_LO];
    assign cmdWrite    = frameWrite & (frameAddr == `RDSRB_ADDR_CMD);
    assign defaultsCmd = cmdWrite & (frameData[`RDSRB_CMD_STANDBY] |
                                     frameData[`RDSRB_CMD_SOFTRST]);

    // ------------------------------------------------------------------------
    // Control bank
    // ------------------------------------------------------------------------
    reg  [3:0]  ctrl_q [0:`RDSRB_CTRL_STORED-1];
    integer     k;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (k = 0; k < `RDSRB_CTRL_STORED; k = k + 1) begin
                ctrl_q[k] <= `RDSRB_CTRL_RESET;
            end
        end else if (defaultsCmd) begin
            for (k = 0; k < `RDSRB_CTRL_STORED; k = k + 1) begin
                ctrl_q[k] <= `RDSRB_CTRL_RESET;
            end
        end else if (frameWrite && (frameAddr < `RDSRB_ADDR_CMD)) begin
            ctrl_q[frameAddr] <= frameData;
        end
    end

    // ------------------------------------------------------------------------
    // Command bits
    // ------------------------------------------------------------------------
    reg         wake_q;
    reg         standby_q;
    reg         softReset_q;
    reg         cpl_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wake_q      <= 1'b0;
            standby_q   <= 1'b0;
            softReset_q <= 1'b0;
            cpl_q       <= 1'b0;
        end else begin
            wake_q      <= cmdWrite & frameData[`RDSRB_CMD_WAKE];
            standby_q   <= cmdWrite & frameData[`RDSRB_CMD_STANDBY];
            softReset_q <= cmdWrite & frameData[`RDSRB_CMD_SOFTRST];
            if (cmdWrite && frameData[`RDSRB_CMD_CPL]) begin
                cpl_q <= 1'b1;
            end else if (frameValid) begin
                cpl_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Channels, diagnosis bank and readback
    // ------------------------------------------------------------------------
    wire [7:0]  diagEn;
    wire [7:0]  olMasked;
    wire [7:0]  chanNext;
    wire [3:0]  pairFault;
    wire [3:0]  diagReg [0:3];
    wire [3:0]  ctrlRead [0:7];
    reg  [7:0]  chanOn_q;

    assign diagEn   = {ctrl_q[`RDSRB_ADDR_DIAGEN_HI], ctrl_q[`RDSRB_ADDR_DIAGEN_LO]};
    assign olMasked = openLoadIn & diagEn;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gChan
            wire [3:0] selReg;
            wire [1:0] sel;
            assign selReg = ctrl_q[g/2];
            assign sel    = selReg[(g%2)*2 +: 2];
            // Lower half follows input two, upper half input three
            assign chanNext[g] = (sel == `RDSRB_SRC_ON)  ? 1'b1 :
                                 (sel == `RDSRB_SRC_IN1) ? in1S :
                                 (sel == `RDSRB_SRC_IN23) ? ((g < 4) ? in2S : in3S) :
                                 1'b0;
            if (g < 4) begin : gPair
                assign pairFault[g] = faultIn[2*g] | faultIn[2*g+1];
                assign diagReg[g]   = {olMasked[2*g+1], faultIn[2*g+1],
                                       olMasked[2*g], faultIn[2*g]};
            end
            if (g < `RDSRB_CTRL_STORED) begin : gRdStored
                assign ctrlRead[g] = ctrl_q[g];
            end else begin : gRdZero
                assign ctrlRead[g] = 4'h0;
            end
        end
    endgenerate

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chanOn_q <= 8'h00;
        end else begin
            chanOn_q <= chanNext;
        end
    end

    // ------------------------------------------------------------------------
    // Pending read and error flag
    // ------------------------------------------------------------------------
    reg  [1:0]  req_q;
    reg  [2:0]  reqAddr_q;
    reg         ter_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_q     <= `RDSRB_REQ_STD;
            reqAddr_q <= 3'h0;
            ter_q     <= `RDSRB_TER_RESET;
        end else if (csnRise) begin
            ter_q <= ~frameValid;
            if (!frameValid || shift_q[`RDSRB_FRM_WRITE] ||
                    shift_q[`RDSRB_FRM_RD_STD]) begin
                req_q <= `RDSRB_REQ_STD;
            end else if (shift_q[`RDSRB_FRM_BANK]) begin
                req_q     <= `RDSRB_REQ_DIAG;
                reqAddr_q <= frameAddr;
            end else begin
                req_q     <= `RDSRB_REQ_CTRL;
                reqAddr_q <= frameAddr;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outgoing word
    // ------------------------------------------------------------------------
    reg  [7:0]  txWord;

    always @* begin
        case (req_q)
            `RDSRB_REQ_CTRL: begin
                txWord = {1'b1, reqAddr_q, ctrlRead[reqAddr_q]};
            end
            `RDSRB_REQ_DIAG: begin
                txWord = {2'b01, reqAddr_q[1:0], diagReg[reqAddr_q[1:0]]};
            end
            default: begin
                txWord = 8'h00;
                txWord[`RDSRB_STD_OPENLOAD] = |olMasked;
                txWord[`RDSRB_STD_AWAKE]    = awakeIn;
                txWord[`RDSRB_STD_LIMPHOME] = limpHomeIn;
                txWord[3:0]                 = pairFault;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Shift register and serial output
    // ------------------------------------------------------------------------
    reg         so_q;
    reg         beforeFirst_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_q       <= 8'h00;
            bitCnt_q      <= 3'h0;
            anyBit_q      <= 1'b0;
            so_q          <= 1'b0;
            beforeFirst_q <= 1'b0;
        end else if (csnFall) begin
            shift_q       <= txWord;
            bitCnt_q      <= 3'h0;
            anyBit_q      <= 1'b0;
            beforeFirst_q <= 1'b1;
            so_q          <= ter_q | siS;
        end else if (sclkRise) begin
            so_q          <= shift_q[7];
            beforeFirst_q <= 1'b0;
        end else if (sclkFall) begin
            shift_q  <= {shift_q[6:0], siS};
            bitCnt_q <= bitCnt_q + 3'h1;
            anyBit_q <= 1'b1;
        end else if (beforeFirst_q && !csnS) begin
            so_q <= ter_q | siS;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign soOut        = so_q;
    assign soOe         = ~csnS;
    assign chanOn       = chanOn_q;
    assign diagEnable   = diagEn;
    assign wakeCmd      = wake_q;
    assign standbyCmd   = standby_q;
    assign softResetCmd = softReset_q;
    assign cplBit       = cpl_q;
    assign terFlag      = ter_q;

endmodule // rdsrb_core

// File: rdsrb_core_chk.sv
`timescale 1ns/1ps
module rdsrb_core_chk (
    // Clock and reset
    input wire        clock,
    input wire        rstn,
    // Serial pins
    input wire        csn,
    input wire        si,
    input wire        soOut,
    input wire        soOe,
    // Control outputs
    input wire [7:0]  chanOn,
    input wire [7:0]  diagEnable,
    input wire        wakeCmd,
    input wire        standbyCmd,
    input wire        softResetCmd,
    input wire        cplBit,
    input wire        terFlag
);
    // ----------------------------------------
    // Cycles since chip select went high
    // ----------------------------------------
    reg  [3:0] hiCnt_q;
    wire       nearEnd = (hiCnt_q >= 4'h1) && (hiCnt_q <= 4'h8);
    wire       anyCmd  = wakeCmd | standbyCmd | softResetCmd;
    always @(posedge clock or negedge rstn) begin
        if (!rstn)
            hiCnt_q <= 4'h0;
        else if (!csn)
            hiCnt_q <= 4'h0;
        else if (hiCnt_q != 4'hF)
            hiCnt_q <= hiCnt_q + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence frameStart;
        $fell(csn);
    endsequence
    a_oe_follow: assert property (frameStart |-> ##[1:4] soOe)
        else $error("output enable late after select");
    a_oe_drop: assert property ($rose(csn) |-> ##[1:4] !soOe)
        else $error("output enable stuck after deselect");
    a_oe_idle: assert property (csn [*6] |-> !soOe)
        else $error("output driven while deselected");
    a_ter_first: assert property (frameStart |-> ##6 (soOut == (terFlag | si)))
        else $error("first output bit not error flag or input");
    a_cmd_pulse: assert property (anyCmd |=> !anyCmd)
        else $error("command pulse longer than one cycle");
    a_cmd_frame: assert property (anyCmd |-> nearEnd)
        else $error("command pulse away from frame end");
    a_reset_cmd: assert property ((standbyCmd || softResetCmd) |-> ##3
        (chanOn == 8'h00 && diagEnable == 8'h00))
        else $error("defaults not restored by command");
    a_regs_quiet: assert property (!$stable(diagEnable) |-> nearEnd)
        else $error("register changed outside frame end");
    a_cpl_hold: assert property (!$stable(cplBit) |-> nearEnd)
        else $error("frame bit changed outside frame end");
    a_ter_quiet: assert property (!$stable(terFlag) |-> nearEnd)
        else $error("error flag changed outside frame end");
endmodule // rdsrb_core_chk

bind rdsrb_core rdsrb_core_chk chk_u (.clock(clock), .rstn(rstn), .csn(csn), .si(si),
    .soOut(soOut), .soOe(soOe), .chanOn(chanOn), .diagEnable(diagEnable),
    .wakeCmd(wakeCmd), .standbyCmd(standbyCmd), .softResetCmd(softResetCmd),
    .cplBit(cplBit), .terFlag(terFlag));

// File: rdsrb_host_model.sv
`timescale 1ns/1ps
module rdsrb_host_model (
    // Serial pins
    output logic  csn,
    output logic  sclk,
    output logic  si,
    input  wire   soOut,
    input  wire   soOe
);
    // ----------------------------------------
    // Serial master, clock idle low
    // ----------------------------------------
    wire soLine = soOe ? soOut : 1'bz;
    initial begin
        csn  = 1'h1;
        sclk = 1'h0;
        si   = 1'h0;
    end
    task automatic xfer(input logic [7:0] cmd, input int nBits,
                        output logic [7:0] rsp, output logic ter);
        logic [8:0] cap;
        cap = 9'h000;
        si = cmd[7];
        #50 csn = 1'h0;
        #250;
        for (int i = 0; i < nBits; i++) begin
            #50 si = cmd[7-i];
            #50 cap = {cap[7:0], soLine};
            sclk = 1'h1;
            #100 sclk = 1'h0;
        end
        #250 cap = {cap[7:0], soLine};
        csn = 1'h1;
        #50 si = 1'h0;
        #450;
        ter = cap[8];
        rsp = cap[7:0];
    endtask
endmodule // rdsrb_host_model

// File: rdsrb_core_tb.sv
`timescale 1ns/1ps
module rdsrb_core_tb;
    logic        clock = 1'h0;
    logic        rstn, parIn1, parIn2, parIn3, awakeIn, limpHomeIn, ter;
    logic [7:0]  faultIn, openLoadIn, rsp, olEn, stdExp;
    logic [3:0]  ctl [8];
    wire         csn, sclk, si, soOut, soOe, wakeCmd, standbyCmd, softResetCmd, cplBit, terFlag;
    wire  [7:0]  chanOn, diagEnable;
    int          err_total = 0, n_checks = 0, nWake = 0, nStb = 0, nRst = 0;
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        nWake += (wakeCmd === 1'h1);
        nStb  += (standbyCmd === 1'h1);
        nRst  += (softResetCmd === 1'h1);
    end
    rdsrb_core dut_u (.clock(clock), .rstn(rstn), .csn(csn), .sclk(sclk), .si(si),
        .soOut(soOut), .soOe(soOe), .parIn1(parIn1), .parIn2(parIn2), .parIn3(parIn3),
        .faultIn(faultIn), .openLoadIn(openLoadIn), .awakeIn(awakeIn),
        .limpHomeIn(limpHomeIn), .chanOn(chanOn), .diagEnable(diagEnable),
        .wakeCmd(wakeCmd), .standbyCmd(standbyCmd), .softResetCmd(softResetCmd),
        .cplBit(cplBit), .terFlag(terFlag));
    rdsrb_host_model host_u (.csn(csn), .sclk(sclk), .si(si), .soOut(soOut), .soOe(soOe));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task frm(input logic [7:0] cmd);
        frmN(cmd, 8);
    endtask
    // Frames start just after a clock edge so pin changes never race sampling
    task frmN(input logic [7:0] cmd, input int nBits);
        @(posedge clock);
        #2;
        host_u.xfer(cmd, nBits, rsp, ter);
    endtask
    task endt(input string s);
        $display("test %s done", s);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] chanExp(input logic [15:0] sel, input logic a, b, c);
        for (int k = 0; k < 8; k++) begin
            case (sel[2*k +: 2])
                2'h0: chanExp[k] = 1'h0;
                2'h1: chanExp[k] = a;
                2'h2: chanExp[k] = (k < 4) ? b : c;
                default: chanExp[k] = 1'h1;
            endcase
        end
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rstn, parIn1, parIn2, parIn3, awakeIn, limpHomeIn} = 6'h00;
        faultIn = 8'h00;
        openLoadIn = 8'h00;
        repeat (3) @(posedge clock);
        #2 rstn = 1'h1;
        chk({6'h00, soOe, terFlag}, 8'h01);
        repeat (4) @(posedge clock);
        frm(8'h02);
        chk({7'h00, ter}, 8'h01);
        chk(rsp, 8'h00);
        chk({7'h00, terFlag}, 8'h00);
        endt("reset");
        ctl = '{4'hD, 4'h8, 4'h6, 4'hB, 4'h5, 4'hA, 4'h0, 4'h0};
        for (int a = 0; a < 8; a++)
            frm({1'h1, a[2:0], ((a == 7) ? 4'hF : (a == 6) ? 4'h1 : ctl[a])});
        for (int a = 0; a < 9; a++) begin
            frm({1'h0, a[2:0], 4'h0});
            if (a > 0) chk(rsp, {1'h1, a[2:0] - 3'h1, ctl[a-1]});
        end
        chk(diagEnable, {ctl[5], ctl[4]});
        endt("control");
        for (int p = 0; p < 8; p++) begin
            @(posedge clock);
            #2 {parIn1, parIn2, parIn3} = p[2:0];
            repeat (8) @(posedge clock);
            chk(chanOn, chanExp({ctl[3], ctl[2], ctl[1], ctl[0]}, parIn1, parIn2, parIn3));
        end
        endt("selectors");
        @(posedge clock);
        #2 faultIn = 8'h24;
        openLoadIn = 8'hC3;
        awakeIn = 1'h1;
        limpHomeIn = 1'h1;
        olEn = 8'hC3 & {ctl[5], ctl[4]};
        stdExp = {1'h0, |olEn, awakeIn, limpHomeIn, |faultIn[7:6], |faultIn[5:4],
                  |faultIn[3:2], |faultIn[1:0]};
        for (int a = 0; a < 5; a++) begin
            frm((a < 4) ? {2'h0, a[1:0], 4'h1} : 8'h02);
            if (a > 0) chk(rsp, {2'h1, a[1:0] - 2'h1, olEn[2*a-1], faultIn[2*a-1],
                                 olEn[2*a-2], faultIn[2*a-2]});
        end
        frm(8'h02);
        chk(rsp, stdExp);
        endt("diagnosis");
        frm(8'hE1);
        chk({7'h00, cplBit}, 8'h01);
        frmN(8'h02, 7);
        chk({6'h00, cplBit, terFlag}, 8'h03);
        frm(8'h02);
        chk({6'h00, cplBit, ter}, 8'h01);
        chk(rsp, stdExp);
        endt("frame bit");
        frm(8'hE8);
        frm(8'hE4);
        chk(diagEnable | chanOn, 8'h00);
        frm(8'hC5);
        frm(8'hE2);
        frm(8'h40);
        frm(8'h02);
        chk(rsp, 8'hC0);
        chk({2'h0, nWake[1:0], nStb[1:0], nRst[1:0]}, 8'h15);
        endt("commands");
        end_sim;
    end
    initial begin
        #1ms;
        err_total++;
        $display("wrong value at %0t: run timed out", $time);
        end_sim;
    end
endmodule // rdsrb_core_tb
